// File: bench/adc_calibration_sequencer_tb.sv
// Self-checking bench of the calibration sequencer.
`timescale 1ns/1ps
module adc_calibration_sequencer_tb
  import cal_seq_pkg::*;
;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        cal_trigger_pin, offset_cal_active, swap_pulse, err, os_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] sample_in, sample_out;
  logic [2:0]  core_online, core_powered;
  logic [1:0]  spare_core;
  int          num_errors, checked, cyc, seed, s0, s1, s2;
  int          n_swap, n_os, n_off, n_sleep;

  // A short step keeps every calibration phase brief.
  adc_calibration_sequencer #(.SAMPLE_W(12), .STEP(16)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_trigger_pin(cal_trigger_pin), .sample_in(sample_in),
    .sample_out(sample_out), .core_online(core_online),
    .core_powered(core_powered), .spare_core(spare_core),
    .offset_cal_active(offset_cal_active), .swap_pulse(swap_pulse)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic trig;
    apb(1'b1, ADDR_TRIG, 32'h0);
    apb(1'b1, ADDR_TRIG, 32'h1);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[BIT_DONE] !== 1'b1 && n < 200);
    chk("done", 32'h1, {31'h0, rd[BIT_DONE]});
  endtask

  function automatic logic [2:0] online_exp(input logic [1:0] s);
    return 3'b111 & ~(3'b001 << s);
  endfunction

  // ----------------------------------------------------------
  // Stimulus, event counters and timeout
  // ----------------------------------------------------------
  always @(posedge pclk) begin
    sample_in <= offset_cal_active ? 12'h0 : 12'($random(seed));
    os_q <= offset_cal_active;
    cyc <= cyc + 1;
    if (swap_pulse === 1'b1) n_swap <= n_swap + 1;
    if (offset_cal_active === 1'b1 && os_q !== 1'b1) n_os <= n_os + 1;
    if (core_online === 3'b000) n_off <= n_off + 1;
    if (core_powered !== 3'b111) n_sleep <= n_sleep + 1;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    seed = 32'h4277;
    {presetn, psel, penable, pwrite, cal_trigger_pin, os_q} = '0;
    {paddr, pwdata, sample_in} = '0;
    ce = 1'b1;
    {num_errors, checked, cyc, n_swap, n_os, n_off, n_sleep} = '0;
    repeat (6) @(posedge pclk);
    chk("powered", 32'h7, core_powered);
    chk("spare", 32'h2, spare_core);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("online", 32'h0, core_online);
    wait_done;
    chk("online", online_exp(2'd2), core_online);
    rdc("sleep", ADDR_SLEEP, {16'h0, SLEEP_RST});
    rdc("settle", ADDR_SETTLE, {16'h0, SETTLE_RST});
    for (int i = 0; i < NUM_TRIMS; i++) begin
      rdc("trim", ADDR_TRIM0 + 8'(4 * i), {20'h0, TRIM_FACTORY});
    end
    s0 = $random(seed) & 32'hfff;
    apb(1'b1, ADDR_TRIM0 + 8'h4, s0);
    rdc("trim", ADDR_TRIM0 + 8'h4, s0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, err);
    // Software trigger: done must drop while the cores are offline, and a
    // low clock enable must hold the calibration where it stands.
    trig;
    ce <= 1'b0;
    repeat (100) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("done", 32'h0, rd[BIT_DONE]);
    chk("online", 32'h0, core_online);
    wait_done;
    // One offset step per foreground run, and trims guarded meanwhile.
    apb(1'b1, ADDR_CTRL, 32'h1 << BIT_FG_OS);
    s0 = n_os;
    trig;
    wait_done;
    chk("os_runs", 32'(s0 + 1), n_os);
    apb(1'b0, ADDR_TRIM0, 32'h0);
    s1 = rd;
    apb(1'b1, ADDR_TRIM0, ~s1 & 32'hfff);
    rdc("trim", ADDR_TRIM0, s1);
    // Pin source: the software trigger is then ignored.
    apb(1'b1, ADDR_CTRL, 32'h1 << BIT_SRC_SEL);
    cal_trigger_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("done", 32'h0, rd[BIT_DONE]);
    cal_trigger_pin <= 1'b0;
    wait_done;
    trig;
    rdc("status", ADDR_STATUS, 32'h21);
    // Background rotation with repeated offset steps.
    apb(1'b1, ADDR_CTRL, 32'h45);
    trig;
    repeat (100) @(posedge pclk);
    {s0, s1, s2} = {n_swap, n_off, n_os};
    repeat (400) @(posedge pclk);
    chk("swaps", 32'h1, 32'(n_swap - s0 >= 2));
    chk("offline", 32'h0, 32'(n_off - s1));
    chk("bg_os", 32'h1, 32'(n_os - s2 >= 2));
    // Low power, automatic swaps after the sleep and settle delays.
    apb(1'b1, ADDR_SLEEP, 32'h8);
    apb(1'b1, ADDR_SETTLE, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h0d);
    repeat (100) @(posedge pclk);
    {s0, s1} = {n_swap, n_sleep};
    repeat (600) @(posedge pclk);
    chk("lp_swaps", 32'h1, 32'(n_swap - s0 >= 2));
    chk("sleeping", 32'h1, 32'(n_sleep > s1));
    // Low power, one swap per user event: software first, then the pin.
    apb(1'b1, ADDR_CTRL, 32'h1d);
    repeat (300) @(posedge pclk);
    s0 = n_swap;
    repeat (300) @(posedge pclk);
    chk("held", 32'h0, 32'(n_swap - s0));
    apb(1'b1, ADDR_TRIG, 32'h1);
    repeat (200) @(posedge pclk);
    chk("user_swap", 32'h1, 32'(n_swap - s0));
    cal_trigger_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    cal_trigger_pin <= 1'b0;
    repeat (200) @(posedge pclk);
    chk("pin_swap", 32'h2, 32'(n_swap - s0));
    // Offset enabled before calibration enable: no repeated steps.
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h20);
    s2 = n_os;
    apb(1'b1, ADDR_CTRL, 32'h65);
    trig;
    repeat (100) @(posedge pclk);
    s0 = n_os;
    repeat (400) @(posedge pclk);
    chk("one_time_os", 32'h0, 32'(n_os - s0));
    chk("os_step_run", 32'h1, 32'(n_os - s2));
    report_and_stop;
  end
endmodule

// File: bench/cal_seq_assertions.sv
// Port checker of the calibration sequencer, attached by bind.
`timescale 1ns/1ps
module cal_seq_checker
  import cal_seq_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [SAMPLE_W-1:0] sample_out,
  input wire logic [2:0]          core_online,
  input wire logic [2:0]          core_powered,
  input wire logic [1:0]          spare_core,
  input wire logic                swap_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------
  ready_after_wait_a: assert property (
    ce && psel && penable && !pready |=> pready)
    else $error("no ready after wait state");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  // The first cycle of each mode is skipped: the two outputs may settle
  // one edge apart.
  fg_mid_code_a: assert property (
    core_online == 3'b000 && $past(core_online) == 3'b000
    |-> sample_out == '0) else $error("sample not mid code");
  stream_pass_a: assert property (
    ce && $past(ce) && core_online != 3'b000 && $past(core_online) != 3'b000
    |-> sample_out == $past(sample_in)) else $error("stream broken");
  online_mask_a: assert property (
    core_online != 3'b000 && $stable(spare_core)
    |-> core_online == (3'b111 & ~(3'b001 << spare_core)))
    else $error("online mask wrong");
  spare_legal_a: assert property (spare_core != 2'd3)
    else $error("spare code illegal");
  swap_pulse_a: assert property (
    swap_pulse |-> core_online != 3'b000 ##1 !swap_pulse)
    else $error("swap pulse wrong");
  power_spare_a: assert property (
    $stable(spare_core) |-> (core_powered | (3'b001 << spare_core)) == 3'b111)
    else $error("active core unpowered");
endmodule

bind adc_calibration_sequencer cal_seq_checker #(.SAMPLE_W(SAMPLE_W)) chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .sample_in(sample_in), .sample_out(sample_out),
  .core_online(core_online), .core_powered(core_powered),
  .spare_core(spare_core), .swap_pulse(swap_pulse)
);

// File: hdl/adc_calibration_sequencer.sv
// Calibration sequencer for the three interleaved converter cores.
`timescale 1ns/1ps
module adc_calibration_sequencer
  import cal_seq_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int STEP     = STEP_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cal_trigger_pin,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output logic      [SAMPLE_W-1:0] sample_out,
  output logic      [2:0]          core_online,
  output logic      [2:0]          core_powered,
  output logic      [1:0]          spare_core,
  output logic                     offset_cal_active,
  output logic                     swap_pulse
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       spare_sleep_delay;
  logic [15:0]       spare_settle_delay;
  logic              cal_software_trigger;
  logic              foreground_cal_done;
  logic              os_once;
  logic              os_owed;
  state_t            state;
  core_t             spare;
  core_t             victim;
  logic [15:0]       timer;
  logic              pin_s1;
  logic              pin_s2;
  logic              pin_d;

  wire cal_enable                  = ctrl[BIT_CAL_EN];
  wire cal_trigger_source_select   = ctrl[BIT_SRC_SEL];
  wire background_cal_enable       = ctrl[BIT_BG_EN];
  wire low_power_bg_enable         = ctrl[BIT_LOW_POWER_BG_ENABLE];
  wire low_power_swap_trigger_mode = ctrl[BIT_LOW_POWER_SWAP_TRIGGER_MODE];
  wire fg_offset_cal_enable        = ctrl[BIT_FG_OS];
  wire bg_offset_cal_enable        = ctrl[BIT_BG_OS];
  wire low_power_background_mode   = background_cal_enable &&
                                     low_power_bg_enable;

  wire apb_first = psel && penable && !pready;
  wire apb_wr    = psel && penable && pwrite;
  wire in_trim   = (paddr >= ADDR_TRIM0) &&
                   (paddr < ADDR_TRIM0 + 8'(4 * NUM_TRIMS));
  wire [2:0] trim_idx = 3'((paddr - ADDR_TRIM0) >> 2);
  wire [TRIM_W-1:0] trim_rd;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_TRIG) || (a == ADDR_SLEEP)
          || (a == ADDR_SETTLE) || (a == ADDR_STATUS) ||
             ((a >= ADDR_TRIM0) && (a < ADDR_TRIM0 + 8'(4 * NUM_TRIMS)));
  endfunction

  // ---------------------------------------------------------------
  // Trigger pin synchroniser and event selection
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d  <= 1'b0;
    end else if (ce) begin
      pin_s1 <= cal_trigger_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // The software bit is a level; an event is taken on its rising write.
  wire sw_write = apb_wr && pready && (paddr == ADDR_TRIG) && ce;
  wire sw_event = sw_write && pwdata[0] && !cal_software_trigger;
  // The bit stays set in background, so a swap request is any write of one.
  wire sw_again = sw_write && pwdata[0];
  wire pin_event = pin_s2 && !pin_d;
  wire user_event = cal_trigger_source_select ? pin_event
                                              : sw_event;
  // Background needs pin select low and software trigger high.
  wire bg_armed = background_cal_enable && cal_enable &&
                  !cal_trigger_source_select && cal_software_trigger;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Offset calibration owns the trims; software writes are dropped.
  wire trim_sw_we = apb_wr && pready && in_trim &&
                    !fg_offset_cal_enable && !bg_offset_cal_enable;
  wire trim_hw_we = (state == st_fg_os || state == st_bg_os) &&
                    (timer == 16'd0);
  wire [TRIM_W-1:0] trim_hw_val =
    TRIM_FACTORY - TRIM_W'(sample_in[SAMPLE_W-1 -: 4]);

  trim_mem #(.DEPTH(NUM_TRIMS), .WIDTH(TRIM_W)) u_trim (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .we      (trim_hw_we || trim_sw_we),
    .waddr   (trim_hw_we ? 3'({victim, 1'b0}) : trim_idx),
    .wdata   (trim_hw_we ? trim_hw_val : pwdata[TRIM_W-1:0]),
    .raddr   (trim_idx),
    .rdata   (trim_rd)
  );

  // One wait state lets the trim memory register its read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= apb_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= apb_first && !mapped(paddr);
      if (apb_first && !pwrite) begin
        unique case (paddr)
          ADDR_CTRL:   prdata <= 32'(ctrl);
          ADDR_TRIG:   prdata <= 32'(cal_software_trigger);
          ADDR_SLEEP:  prdata <= 32'(spare_sleep_delay);
          ADDR_SETTLE: prdata <= 32'(spare_settle_delay);
          ADDR_STATUS: prdata <= 32'({spare, 2'b00,
                                      state != st_idle,
                                      foreground_cal_done});
          default:     prdata <= in_trim ? 32'(trim_rd) : 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                 <= '0;
      spare_sleep_delay    <= SLEEP_RST;
      spare_settle_delay   <= SETTLE_RST;
      cal_software_trigger <= 1'b0;
    end else if (ce && apb_wr && pready) begin
      unique case (paddr)
        ADDR_CTRL:   ctrl <= pwdata[CTRL_W-1:0];
        ADDR_TRIG:   cal_software_trigger <= pwdata[0];
        ADDR_SLEEP:  spare_sleep_delay <= pwdata[15:0];
        ADDR_SETTLE: spare_settle_delay <= pwdata[15:0];
        default:     ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Latched when calibration is enabled with the one-time offset set;
  // the single offset step stays owed until background has run it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_once <= 1'b0;
      os_owed <= 1'b0;
    end else if (ce) begin
      if (apb_wr && pready && paddr == ADDR_CTRL &&
          pwdata[BIT_CAL_EN] && !cal_enable) begin
        os_once <= fg_offset_cal_enable;
        os_owed <= fg_offset_cal_enable;
      end else if (state == st_bg_os && timer == 16'd0) begin
        os_owed <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= st_fg_cal;
      timer               <= 16'(STEP);
      spare               <= core_c;
      victim              <= core_a;
      foreground_cal_done <= 1'b0;
      swap_pulse          <= 1'b0;
    end else if (ce) begin
      swap_pulse <= 1'b0;
      if (timer != 16'd0) begin
        timer <= timer - 16'd1;
      end
      unique case (state)
        st_idle: begin
          if (bg_armed) begin
            state  <= st_bg_wait;
            victim <= core_a;
            spare  <= core_c;
          end else if (user_event) begin
            state               <= st_fg_cal;
            timer               <= 16'(STEP);
            foreground_cal_done <= 1'b0;
          end
        end
        st_fg_cal: if (timer == 16'd0) begin
          timer <= 16'(STEP);
          if (fg_offset_cal_enable) begin
            state <= st_fg_os;
          end else begin
            state               <= st_idle;
            foreground_cal_done <= 1'b1;
          end
        end
        st_fg_os: if (timer == 16'd0) begin
          state               <= st_idle;
          foreground_cal_done <= 1'b1;
        end
        st_bg_wait: begin
          if (!bg_armed) begin
            state <= st_idle;
          end else if (!low_power_background_mode) begin
            state <= st_bg_cal;
            timer <= 16'(STEP);
          end else if (!low_power_swap_trigger_mode) begin
            state <= st_bg_sleep;
            timer <= spare_sleep_delay;
          end else if (sw_again || pin_event) begin
            state <= st_bg_settle;
            timer <= spare_settle_delay;
          end
        end
        st_bg_sleep: if (timer == 16'd0) begin
          state <= st_bg_settle;
          timer <= spare_settle_delay;
        end
        st_bg_settle: if (timer == 16'd0) begin
          state <= st_bg_cal;
          timer <= 16'(STEP);
        end
        st_bg_cal: if (timer == 16'd0) begin
          timer <= 16'(STEP);
          state <= ((bg_offset_cal_enable && !os_once) || os_owed) ?
                   st_bg_os : st_bg_swap;
        end
        st_bg_os: if (timer == 16'd0) begin
          state <= st_bg_swap;
        end
        st_bg_swap: begin
          // Spare takes the victim's slot; the victim becomes spare.
          swap_pulse <= 1'b1;
          spare      <= victim;
          victim     <= (victim == core_a || spare == core_a) ?
                        ((victim == core_b) ? core_c : core_b) : core_a;
          state      <= st_bg_wait;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Core power, online set and sample path
  // ---------------------------------------------------------------
  wire fg_busy = (state == st_fg_cal) || (state == st_fg_os);
  wire spare_up = !low_power_background_mode ||
                  state == st_bg_settle || state == st_bg_cal ||
                  state == st_bg_os || state == st_bg_swap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_online       <= 3'b000;
      core_powered      <= 3'b111;
      spare_core        <= 2'(core_c);
      offset_cal_active <= 1'b0;
    end else if (ce) begin
      spare_core        <= 2'(spare);
      offset_cal_active <= (state == st_fg_os) || (state == st_bg_os);
      if (fg_busy) begin
        core_online <= 3'b000;
      end else begin
        core_online <= ~(3'b001 << spare);
      end
      core_powered <= spare_up ? 3'b111 : ~(3'b001 << spare);
    end
  end

  // Swaps may glitch the stream briefly; no attempt is made to hide it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out <= SAMPLE_W'(MID_CODE);
    end else if (ce) begin
      sample_out <= fg_busy ? SAMPLE_W'(MID_CODE)
                            : sample_in;
    end
  end

endmodule

// File: hdl/cal_seq_pkg.sv
// Constants, types and register map of the calibration sequencer.
package cal_seq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TRIG   = 8'h04;
  localparam logic [7:0] ADDR_SLEEP  = 8'h08;
  localparam logic [7:0] ADDR_SETTLE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TRIM0  = 8'h20;
  localparam int         NUM_TRIMS   = 6;
  localparam int         TRIM_W      = 12;

  // Control register fields.
  localparam int BIT_CAL_EN     = 0;
  localparam int BIT_SRC_SEL    = 1;
  localparam int BIT_BG_EN      = 2;
  localparam int BIT_LOW_POWER_BG_ENABLE      = 3;
  localparam int BIT_LOW_POWER_SWAP_TRIGGER_MODE    = 4;
  localparam int BIT_FG_OS      = 5;
  localparam int BIT_BG_OS      = 6;
  localparam int CTRL_W         = 7;

  // Status register fields.
  localparam int BIT_DONE       = 0;
  localparam int BIT_BUSY       = 1;
  localparam int BIT_SPARE_LO   = 4;

  // ---------------------------------------------------------------
  // Timing and reset values
  // ---------------------------------------------------------------
  localparam int          STEP_CYCLES   = 64;
  localparam logic [15:0] SLEEP_RST     = 16'h0100;
  localparam logic [15:0] SETTLE_RST    = 16'h0010;
  localparam logic [TRIM_W-1:0] TRIM_FACTORY = 12'h800;
  localparam logic [11:0] MID_CODE      = 12'h000;

  typedef enum logic [1:0] {core_a, core_b, core_c} core_t;
  typedef enum {
    st_fg_cal, st_fg_os, st_idle, st_bg_wait, st_bg_sleep,
    st_bg_settle, st_bg_cal, st_bg_os, st_bg_swap
  } state_t;

endpackage

// File: hdl/trim_mem.sv
// Small register memory for the input offset trims.
`timescale 1ns/1ps
module trim_mem
  import cal_seq_pkg::*;
#(
  parameter int DEPTH = NUM_TRIMS,
  parameter int WIDTH = TRIM_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [2:0]       waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [2:0]       raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Factory values load at reset; the array is then freely rewritten.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= TRIM_FACTORY;
      end
    end else if (ce && we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
  end

endmodule
